// [hdl/rx_cmd_pkg.sv]
// constants and types for the receive-path direct command unit
// Notes on behaviour
// R1: analog preset loads tx/rx configuration fields from mode and bit rate inputs.
// R2: preset sets modulation type 0 for type A and 106k peer, else 1.
// R3: preset sets field detector enable only for active peer modes.
// R4: preset clears rx channel select (AM channel) for active peer modes.
// R5: preset selects peak detector for all rx rates up to fc/16.
// R6: preset loads low-pass and zero setting bits per mode and rx rate.
// R7: preset sets stage clipping bit only for active peer modes.
// R8: preset sets forced gain reduction bit only for active peer modes.
// R9: mask command drops rx_on and stops receive framing.
// R10: effective mask is command mask OR mask timer mask.
// R11: unmask command raises rx_on and re-enables receive framing.
// R12: unmask during running mask timer enables reception and resets that timer.
// R13: mask and unmask accepted only while receiver enabled.
// R14: mask, unmask and gain reset may be chained within one select period.
// R15: no termination interrupt for mask, unmask, squelch and gain reset.
// R16: host chains nothing after measure amplitude or squelch in one frame.
// R17: termination interrupt once measure amplitude finishes.
// R18: measure amplitude enables tx and detector, absolute converter, stores result.
// R19: amplitude code step is 13.02 mVpp; full scale 3 Vpp gives e6.
// R20: measure amplitude completes within 25 us.
// R21: measure amplitude and gain reset need global enable and stable oscillator.
// R22: squelch completes within 500 us.
// R23: squelch accepted with tx and rx on, executed only while rx_on low.
// R24: gain reset reinits agc, aborts squelch, clears setting, loads manual gain.
// R25: commands whose conditions fail are ignored without side effects; a refused measure amplitude or squelch still blocks the rest of its frame.
package rx_cmd_pkg;
    localparam logic [5:0] ADDR_AUX = 6'h09;
    localparam logic [5:0] ADDR_RXF = 6'h0a;
    localparam logic [5:0] ADDR_RXG = 6'h0c;
    localparam int AUX_TX_MOD_BIT = 5;
    localparam int AUX_FD_BIT = 4;
    localparam int RXF_RX_CHANNEL_SELECT_BIT = 7;
    localparam int RXF_AMD_BIT = 6;
    localparam int RXG_CLIP_BIT = 1;
    localparam int RXG_PEER_GAIN_BIT = 0;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] RXF_RST = 8'h00;
    localparam logic [7:0] RXG_RST = 8'h00;
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CMD = 2'h3;
    localparam logic [5:0] CMD_ANALOG_PRESET = 6'h0a;
    localparam logic [5:0] CMD_MASK_RX = 6'h10;
    localparam logic [5:0] CMD_UNMASK_RX = 6'h11;
    localparam logic [5:0] CMD_MEAS_AMP = 6'h13;
    localparam logic [5:0] CMD_SQUELCH = 6'h1d;
    localparam logic [5:0] CMD_GAIN_RESET = 6'h1e;
    localparam logic [3:0] MODE_PEER_INIT = 4'h0;
    localparam logic [3:0] MODE_TYPE_A = 4'h1;
    localparam logic [3:0] MODE_TYPE_B = 4'h2;
    localparam logic [3:0] MODE_VICINITY = 4'h3;
    localparam logic [3:0] MODE_TYPE_F = 4'h4;
    localparam logic [3:0] MODE_PEER_TARGET = 4'h9;
    localparam logic [1:0] RATE_106 = 2'h0;
    localparam logic [1:0] RATE_FC16 = 2'h3;
    localparam logic [5:0] FILT_PEER = 6'h00;
    localparam logic [5:0] FILT_TYPE_A = 6'h08;
    localparam logic [5:0] FILT_TYPE_B = 6'h04;
    localparam logic [5:0] FILT_VICINITY = 6'h13;
    localparam logic [5:0] FILT_TYPE_F = 6'h18;
    localparam logic [5:0] FILT_HIGH_RATE = 6'h20;
    localparam logic [7:0] AMP_FULL_SCALE = 8'he6;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MEAS_TIME_NS = 25000;
    localparam int SQUELCH_TIME_NS = 500000;
    localparam int MEAS_CYC = MEAS_TIME_NS / CLK_PERIOD_NS;
    localparam int SQUELCH_CYC = SQUELCH_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 17;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_MEAS = 2'h1,
        ST_SQUELCH = 2'h3
    } cmd_state_t;
endpackage

// [hdl/bit_sync.sv]
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_st_t;
    sync_st_t st_r;
    sync_st_t st_nxt;
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.s2;
endmodule // bit_sync
`default_nettype wire

// [hdl/cmd_timer.sv]
// loadable down counter with done pulse and abort
`timescale 1ns/1ps
`default_nettype none
module cmd_timer #(
    parameter int W = rx_cmd_pkg::TMR_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic clr,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } tmr_st_t;
    tmr_st_t st_r;
    tmr_st_t st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (clr) begin
            st_nxt.cnt = '0;
        end else if (load) begin
            st_nxt.cnt = load_val;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - W'(1);
            st_nxt.done = (st_r.cnt == W'(1));
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign busy = (st_r.cnt != '0);
    assign done = st_r.done;
endmodule // cmd_timer
`default_nettype wire

// [hdl/rx_direct_command_unit.sv]
// serial command front end and receive-path direct command engine
`timescale 1ns/1ps
`default_nettype none
module rx_direct_command_unit #(
    parameter int SQUELCH_CYC = rx_cmd_pkg::SQUELCH_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic [3:0] op_mode,
    input wire logic [1:0] tx_bit_rate,
    input wire logic [1:0] rx_bit_rate,
    input wire logic global_enable,
    input wire logic xtal_stable,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic mask_timer_running,
    input wire logic [3:0] manual_gain,
    input wire logic [7:0] amp_adc_code,
    input wire logic squelch_raise,
    output logic [7:0] protocol_aux_config,
    output logic [7:0] receiver_filter_config,
    output logic [7:0] receiver_gain_config,
    output logic rx_on,
    output logic framing_enable,
    output logic mask_timer_reset,
    output logic tx_force_on,
    output logic amp_detector_enable,
    output logic adc_abs_mode,
    output logic [7:0] adc_result,
    output logic cmd_done_irq,
    output logic squelch_run,
    output logic agc_reset,
    output logic [3:0] gain_reduction,
    output logic [3:0] squelch_setting
);
    // ---------------- link side, on sclk ----------------
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] sh;
        logic first;
    } frame_st_t;
    typedef struct packed {
        logic [7:0] rx_byte;
        logic byte_first;
        logic tog;
    } hold_st_t;
    frame_st_t fr_r;
    frame_st_t fr_nxt;
    hold_st_t hd_r;
    hold_st_t hd_nxt;

    always_comb begin
        fr_nxt = fr_r;
        hd_nxt = hd_r;
        fr_nxt.sh = {fr_r.sh[5:0], mosi};
        fr_nxt.bit_cnt = fr_r.bit_cnt + 3'h1;
        if (fr_r.bit_cnt == 3'h7) begin
            hd_nxt.rx_byte = {fr_r.sh, mosi};
            hd_nxt.byte_first = fr_r.first;
            hd_nxt.tog = ~hd_r.tog;
            fr_nxt.first = 1'b0;
        end
    end
    // frame state ends with the select line itself
    always_ff @(posedge sclk or posedge ss_n or negedge rst_n) begin
        if (ss_n || !rst_n) begin
            fr_r <= '{bit_cnt: 3'h0, sh: 7'h00, first: 1'b1};
        end else begin
            fr_r <= fr_nxt;
        end
    end
    // byte holder survives frame end so the toggle stays consistent
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            hd_r <= '0;
        end else if (!ss_n) begin
            hd_r <= hd_nxt;
        end
    end

    // ---------------- core side, on ref_clk ----------------
    logic tog_s;
    bit_sync u_tog_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d(hd_r.tog),
        .q(tog_s)
    );

    typedef struct packed {
        logic [7:0] aux;
        logic [7:0] rxf;
        logic [7:0] rxg;
        logic rx_mask;
        logic tog_d;
        logic wr_pend;
        logic [5:0] wr_addr;
        logic blocked;
        rx_cmd_pkg::cmd_state_t state;
        logic [7:0] adc;
        logic done_irq;
        logic tmr_rst;
        logic agc_rst;
        logic [3:0] gain_red;
        logic [3:0] sq_set;
    } core_st_t;
    core_st_t st_r;
    core_st_t st_nxt;

    logic ev;
    logic is_cmd;
    logic [5:0] code;
    logic peer;
    logic run_ok;
    logic preset_acc;
    logic mask_acc;
    logic unmask_acc;
    logic meas_acc;
    logic sq_acc;
    logic gain_acc;
    logic tmr_load;
    logic [rx_cmd_pkg::TMR_W-1:0] tmr_val;
    logic tmr_busy;
    logic tmr_done;
    logic [5:0] filt;

    // byte is held stable for a full byte time on the link after the toggle
    assign ev = tog_s ^ st_r.tog_d;
    assign is_cmd = hd_r.rx_byte[7:6] == rx_cmd_pkg::OP_CMD;
    assign code = hd_r.rx_byte[5:0];
    assign peer = (op_mode == rx_cmd_pkg::MODE_PEER_INIT) || (op_mode == rx_cmd_pkg::MODE_PEER_TARGET);
    assign run_ok = global_enable && xtal_stable; // R21

    always_comb begin
        logic live;
        logic pend;
        live = ev && (hd_r.byte_first || !st_r.blocked); // R14
        pend = st_r.wr_pend && !hd_r.byte_first;
        preset_acc = 1'b0;
        mask_acc = 1'b0;
        unmask_acc = 1'b0;
        meas_acc = 1'b0;
        sq_acc = 1'b0;
        gain_acc = 1'b0;
        if (live && !pend && is_cmd) begin // R25
            preset_acc = (code == rx_cmd_pkg::CMD_ANALOG_PRESET); // R1
            mask_acc = (code == rx_cmd_pkg::CMD_MASK_RX) && rx_enable; // R13
            unmask_acc = (code == rx_cmd_pkg::CMD_UNMASK_RX) && rx_enable; // R13
            meas_acc = (code == rx_cmd_pkg::CMD_MEAS_AMP) && run_ok
                && (st_r.state == rx_cmd_pkg::ST_IDLE); // R21
            sq_acc = (code == rx_cmd_pkg::CMD_SQUELCH) && tx_enable && rx_enable
                && (st_r.state == rx_cmd_pkg::ST_IDLE); // R23
            gain_acc = (code == rx_cmd_pkg::CMD_GAIN_RESET) && run_ok; // R21
        end
    end

    // low-pass and zero bits per mode and receive rate
    always_comb begin
        case (op_mode)
            rx_cmd_pkg::MODE_PEER_INIT,
            rx_cmd_pkg::MODE_PEER_TARGET: filt = rx_cmd_pkg::FILT_PEER;
            rx_cmd_pkg::MODE_TYPE_A: filt = rx_cmd_pkg::FILT_TYPE_A;
            rx_cmd_pkg::MODE_TYPE_B: filt = rx_cmd_pkg::FILT_TYPE_B;
            rx_cmd_pkg::MODE_VICINITY: filt = rx_cmd_pkg::FILT_VICINITY;
            rx_cmd_pkg::MODE_TYPE_F: filt = rx_cmd_pkg::FILT_TYPE_F;
            default: filt = rx_cmd_pkg::FILT_TYPE_A;
        endcase
        if (!peer && (op_mode != rx_cmd_pkg::MODE_VICINITY) && (rx_bit_rate != rx_cmd_pkg::RATE_106)) begin
            filt = rx_cmd_pkg::FILT_HIGH_RATE; // R6
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.tog_d = tog_s;
        st_nxt.done_irq = 1'b0;
        st_nxt.tmr_rst = 1'b0;
        st_nxt.agc_rst = 1'b0;
        tmr_load = 1'b0;
        tmr_val = '0;
        if (ev) begin
            if (hd_r.byte_first) begin
                st_nxt.blocked = 1'b0;
                st_nxt.wr_pend = 1'b0;
            end
            if (hd_r.byte_first || !st_r.blocked) begin
                if (st_r.wr_pend && !hd_r.byte_first) begin
                    st_nxt.wr_pend = 1'b0;
                    case (st_r.wr_addr)
                        rx_cmd_pkg::ADDR_AUX: st_nxt.aux = hd_r.rx_byte;
                        rx_cmd_pkg::ADDR_RXF: st_nxt.rxf = hd_r.rx_byte;
                        rx_cmd_pkg::ADDR_RXG: st_nxt.rxg = hd_r.rx_byte;
                        default: st_nxt.wr_pend = 1'b0;
                    endcase
                end else if (hd_r.rx_byte[7:6] == rx_cmd_pkg::OP_WRITE) begin
                    st_nxt.wr_pend = 1'b1;
                    st_nxt.wr_addr = code;
                end else if (is_cmd && ((code == rx_cmd_pkg::CMD_MEAS_AMP) || (code == rx_cmd_pkg::CMD_SQUELCH))) begin
                    st_nxt.blocked = 1'b1; // R16
                end
            end
        end
        if (preset_acc) begin
            st_nxt.aux[rx_cmd_pkg::AUX_TX_MOD_BIT] = !((op_mode == rx_cmd_pkg::MODE_TYPE_A)
                || (peer && (tx_bit_rate == rx_cmd_pkg::RATE_106))); // R2
            st_nxt.aux[rx_cmd_pkg::AUX_FD_BIT] = peer; // R3
            if (peer) begin
                st_nxt.rxf[rx_cmd_pkg::RXF_RX_CHANNEL_SELECT_BIT] = 1'b0; // R4
            end
            st_nxt.rxf[rx_cmd_pkg::RXF_AMD_BIT] = (rx_bit_rate > rx_cmd_pkg::RATE_FC16); // R5
            st_nxt.rxf[5:0] = filt; // R6
            st_nxt.rxg[rx_cmd_pkg::RXG_CLIP_BIT] = peer; // R7
            st_nxt.rxg[rx_cmd_pkg::RXG_PEER_GAIN_BIT] = peer; // R8
        end
        if (mask_acc) begin
            st_nxt.rx_mask = 1'b1; // R9
        end
        if (unmask_acc) begin
            st_nxt.rx_mask = 1'b0; // R11
            st_nxt.tmr_rst = mask_timer_running; // R12
        end
        if (meas_acc) begin
            st_nxt.state = rx_cmd_pkg::ST_MEAS; // R18
            tmr_load = 1'b1;
            tmr_val = rx_cmd_pkg::TMR_W'(rx_cmd_pkg::MEAS_CYC - 1); // R20
        end
        if (sq_acc && !rx_on) begin
            st_nxt.state = rx_cmd_pkg::ST_SQUELCH; // R23
            tmr_load = 1'b1;
            tmr_val = rx_cmd_pkg::TMR_W'(SQUELCH_CYC - 1); // R22
        end
        case (st_r.state)
            rx_cmd_pkg::ST_IDLE: st_nxt.state = st_nxt.state;
            rx_cmd_pkg::ST_MEAS: begin
                if (tmr_done) begin
                    st_nxt.adc = (amp_adc_code > rx_cmd_pkg::AMP_FULL_SCALE) ?
                        rx_cmd_pkg::AMP_FULL_SCALE : amp_adc_code; // R19
                    st_nxt.done_irq = 1'b1; // R17
                    st_nxt.state = rx_cmd_pkg::ST_IDLE;
                end
            end
            rx_cmd_pkg::ST_SQUELCH: begin
                if (squelch_raise) begin
                    st_nxt.sq_set = st_r.sq_set + 4'h1;
                end
                if (tmr_done) begin
                    st_nxt.state = rx_cmd_pkg::ST_IDLE; // R15
                end
            end
            default: st_nxt.state = rx_cmd_pkg::ST_IDLE;
        endcase
        if (gain_acc) begin
            st_nxt.agc_rst = 1'b1; // R24
            st_nxt.sq_set = 4'h0;
            st_nxt.gain_red = manual_gain;
            if (st_r.state == rx_cmd_pkg::ST_SQUELCH) begin
                st_nxt.state = rx_cmd_pkg::ST_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '{aux: rx_cmd_pkg::AUX_RST, rxf: rx_cmd_pkg::RXF_RST, rxg: rx_cmd_pkg::RXG_RST,
                state: rx_cmd_pkg::ST_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    cmd_timer #(
        .W(rx_cmd_pkg::TMR_W)
    ) u_timer (
        .clk(ref_clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .clr(gain_acc && (st_r.state == rx_cmd_pkg::ST_SQUELCH)),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    assign protocol_aux_config = st_r.aux;
    assign receiver_filter_config = st_r.rxf;
    assign receiver_gain_config = st_r.rxg;
    assign rx_on = rx_enable && !(st_r.rx_mask || mask_timer_running); // R10
    assign framing_enable = rx_on;
    assign mask_timer_reset = st_r.tmr_rst;
    assign tx_force_on = (st_r.state == rx_cmd_pkg::ST_MEAS);
    assign amp_detector_enable = (st_r.state == rx_cmd_pkg::ST_MEAS);
    assign adc_abs_mode = (st_r.state == rx_cmd_pkg::ST_MEAS);
    assign adc_result = st_r.adc;
    assign cmd_done_irq = st_r.done_irq;
    assign squelch_run = (st_r.state == rx_cmd_pkg::ST_SQUELCH) && tmr_busy;
    assign agc_reset = st_r.agc_rst;
    assign gain_reduction = st_r.gain_red;
    assign squelch_setting = st_r.sq_set;

    // ---------------- checks ----------------
    localparam int MEAS_N = rx_cmd_pkg::MEAS_CYC;
    logic [11:0] meas_cnt_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meas_cnt_r <= 12'h000;
        end else if (st_r.state == rx_cmd_pkg::ST_MEAS) begin
            meas_cnt_r <= meas_cnt_r + 12'h001;
        end else begin
            meas_cnt_r <= 12'h000;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_meas_start;
        meas_acc ##1 amp_detector_enable && adc_abs_mode && tx_force_on;
    endsequence
    sequence s_meas_hold;
        amp_detector_enable [*8];
    endsequence

    a_mask_rx_low: assert property (mask_acc |=> !rx_on && !framing_enable) // R9
        else $error("rx_on still high after mask");
    a_timer_mask_or: assert property (mask_timer_running |-> !framing_enable) // R10
        else $error("framing enabled while mask timer runs");
    a_unmask_rx_high: assert property (unmask_acc && !mask_timer_running ##1 !mask_timer_running
        |-> rx_on) // R11
        else $error("rx_on low after unmask");
    a_unmask_timer_rst: assert property (unmask_acc && mask_timer_running |=> mask_timer_reset) // R12
        else $error("mask timer not reset by unmask");
    a_mask_needs_rx: assert property (ev && is_cmd && !rx_enable |=> st_r.rx_mask == $past(st_r.rx_mask)) // R13
        else $error("mask state changed with receiver off");
    a_irq_only_meas: assert property (cmd_done_irq |-> $past(st_r.state) == rx_cmd_pkg::ST_MEAS) // R15
        else $error("termination interrupt from other command");
    a_meas_time_irq: assert property (cmd_done_irq |-> meas_cnt_r == 12'(MEAS_N)) // R17
        else $error("measure amplitude length wrong");
    a_meas_drives: assert property (s_meas_start |-> s_meas_hold) // R18
        else $error("amplitude path not held during measure");
    a_meas_clamp: assert property (cmd_done_irq |-> adc_result <= rx_cmd_pkg::AMP_FULL_SCALE) // R19
        else $error("amplitude result above full scale");
    a_meas_gate: assert property (ev && is_cmd && !run_ok |=> !amp_detector_enable
        || $past(amp_detector_enable)) // R21
        else $error("measure started without enable");
    a_preset_peer: assert property (preset_acc && peer |=> protocol_aux_config[rx_cmd_pkg::AUX_FD_BIT]
        && !receiver_filter_config[rx_cmd_pkg::RXF_RX_CHANNEL_SELECT_BIT]
        && receiver_gain_config[rx_cmd_pkg::RXG_CLIP_BIT]
        && receiver_gain_config[rx_cmd_pkg::RXG_PEER_GAIN_BIT]) // R3
        else $error("peer preset bits wrong");
    a_preset_mod: assert property (preset_acc && op_mode == rx_cmd_pkg::MODE_TYPE_B
        |=> protocol_aux_config[rx_cmd_pkg::AUX_TX_MOD_BIT] && !protocol_aux_config[rx_cmd_pkg::AUX_FD_BIT]) // R2
        else $error("type B preset wrong");
    a_squelch_gate: assert property (sq_acc && rx_on && st_r.state == rx_cmd_pkg::ST_IDLE
        |=> !squelch_run) // R23
        else $error("squelch ran with rx_on high");
    a_gain_reset: assert property (gain_acc |=> agc_reset && squelch_setting == 4'h0
        && gain_reduction == $past(manual_gain) && !squelch_run) // R24
        else $error("gain reset effects missing");
endmodule // rx_direct_command_unit
`default_nettype wire

// [testbench/spi_host_model.sv]
// host-side serial master model driving the command link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic sclk,
    output logic ss_n,
    output logic mosi
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b1;
    end
    // one frame, msb first, 12 ns clock only inside the frame
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                ss_n = 1'b0;
                mosi = b[i][k];
                #6 sclk = 1'b1;
                #6 sclk = 1'b0;
            end
        end
        #6 ss_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule // spi_host_model
`default_nettype wire

// [testbench/rx_direct_command_unit_bench.sv]
// self-checking bench for the receive-path direct command unit
`timescale 1ns/1ps
`default_nettype none
module rx_direct_command_unit_bench;
    localparam int SQ = 60;
    logic ref_clk, rst_n, sclk, ss_n, mosi, pr;
    logic [3:0] op_mode, manual_gain, gain_reduction, squelch_setting;
    logic [1:0] tx_bit_rate, rx_bit_rate, tr;
    logic global_enable, xtal_stable, rx_enable, tx_enable, mask_timer_running, squelch_raise;
    logic [7:0] amp_adc_code, aux, rxf, rxg, adc_result;
    logic rx_on, framing_enable, mask_timer_reset, tx_force_on, amp_detector_enable, adc_abs_mode;
    logic cmd_done_irq, squelch_run, agc_reset;
    logic [31:0] lfsr = 32'h380f;
    logic [3:0] modes[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
    logic [5:0] filt[6] = '{6'h00, 6'h08, 6'h04, 6'h13, 6'h18, 6'h00};
    int mismatches, n_tests, n_irq, n_tr, n_agc, n_amp, w;

    spi_host_model u_host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi));
    rx_direct_command_unit #(.SQUELCH_CYC(SQ)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .op_mode(op_mode), .tx_bit_rate(tx_bit_rate), .rx_bit_rate(rx_bit_rate),
        .global_enable(global_enable), .xtal_stable(xtal_stable), .rx_enable(rx_enable),
        .tx_enable(tx_enable), .mask_timer_running(mask_timer_running), .manual_gain(manual_gain),
        .amp_adc_code(amp_adc_code), .squelch_raise(squelch_raise), .protocol_aux_config(aux),
        .receiver_filter_config(rxf), .receiver_gain_config(rxg), .rx_on(rx_on),
        .framing_enable(framing_enable), .mask_timer_reset(mask_timer_reset), .tx_force_on(tx_force_on),
        .amp_detector_enable(amp_detector_enable), .adc_abs_mode(adc_abs_mode), .adc_result(adc_result),
        .cmd_done_irq(cmd_done_irq), .squelch_run(squelch_run), .agc_reset(agc_reset),
        .gain_reduction(gain_reduction), .squelch_setting(squelch_setting));

    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // event counters; the bench also plays the mask timer
    always @(posedge ref_clk) begin
        n_irq += (cmd_done_irq === 1'b1);
        n_tr += (mask_timer_reset === 1'b1);
        n_agc += (agc_reset === 1'b1);
        n_amp += (tx_force_on & amp_detector_enable & adc_abs_mode) === 1'b1;
    end
    initial begin
        #150000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {op_mode, manual_gain, tx_bit_rate, rx_bit_rate, amp_adc_code} = '0;
        {global_enable, xtal_stable, rx_enable, tx_enable, mask_timer_running, squelch_raise} = '0;
        #1 rst_n = 1'b0;
        cyc(20);
        rst_n <= 1'b1;
        cyc(4);
        foreach (modes[i]) begin
            lfsr = rnd(lfsr);
            tr = 2'(lfsr % 3);
            pr = modes[i] == 4'h0 || modes[i] == 4'h9;
            @(posedge ref_clk);
            op_mode <= modes[i];
            tx_bit_rate <= tr;
            rx_bit_rate <= tr;
            u_host.send('{8'h0a, 8'hff, 8'h0c, 8'hfc, 8'hca});
            cyc(8);
            check(16'(aux), {10'h0, !(modes[i] == 4'h1 || pr && tr == 2'h0), pr, 4'h0});
            check(16'(rxf), {8'h0, !pr, 1'b0, (!pr && modes[i] != 4'h3 && tr != 2'h0) ? 6'h20 : filt[i]});
            check(16'(rxg), {8'h0, 6'h3f, pr, pr});
        end
        u_host.send('{8'hd0});
        cyc(8);
        @(posedge ref_clk) rx_enable <= 1'b1;
        cyc(2);
        check(16'(rx_on), 16'h0001);
        u_host.send('{8'hd0});
        cyc(8);
        check({14'h0, rx_on, framing_enable}, 16'h0000);
        @(posedge ref_clk) mask_timer_running <= 1'b1;
        u_host.send('{8'hd1});
        while (mask_timer_reset !== 1'b1) @(posedge ref_clk);
        mask_timer_running <= 1'b0;
        cyc(8);
        check({14'h0, rx_on, framing_enable}, 16'h0003);
        check(16'(n_tr), 16'h0001);
        @(posedge ref_clk) mask_timer_running <= 1'b1;
        cyc(2);
        check(16'(rx_on), 16'h0000);
        @(posedge ref_clk) mask_timer_running <= 1'b0;
        u_host.send('{8'hde, 8'hd3});
        cyc(3200);
        check(16'(n_agc + n_irq), 16'h0000);
        lfsr = rnd(lfsr);
        @(posedge ref_clk);
        global_enable <= 1'b1;
        xtal_stable <= 1'b1;
        manual_gain <= lfsr[3:0];
        amp_adc_code <= lfsr[15:8];
        u_host.send('{8'hd0, 8'hde, 8'hd1});
        cyc(8);
        check({11'h0, rx_on, gain_reduction}, {11'h0, 1'b1, manual_gain});
        check(16'(n_agc), 16'h0001);
        u_host.send('{8'hd3});
        w = 0;
        while (n_irq == 0 && w < 3300) begin
            @(posedge ref_clk);
            w++;
        end
        check(16'(w < 3140), 16'h0001);
        check(16'(adc_result), 16'(amp_adc_code > 8'he6 ? 8'he6 : amp_adc_code));
        check(16'(n_amp), 16'h0c35);
        cyc(4);
        check(16'(n_irq), 16'h0001);
        @(posedge ref_clk) tx_enable <= 1'b1;
        u_host.send('{8'hdd});
        cyc(8);
        check(16'(squelch_run), 16'h0000);
        u_host.send('{8'hd0, 8'hdd});
        cyc(6);
        check(16'(squelch_run), 16'h0001);
        @(posedge ref_clk) squelch_raise <= 1'b1;
        @(posedge ref_clk) squelch_raise <= 1'b0;
        cyc(2);
        check(16'(squelch_setting), 16'h0001);
        w = 0;
        while (squelch_run !== 1'b0 && w < 80) begin
            @(posedge ref_clk);
            w++;
        end
        check(16'(w < 62), 16'h0001);
        check(16'(n_irq), 16'h0001);
        u_host.send('{8'hdd});
        cyc(6);
        u_host.send('{8'hde});
        cyc(8);
        check({11'h0, squelch_run, squelch_setting}, 16'h0000);
        tally_and_finish();
    end
endmodule // rx_direct_command_unit_bench
`default_nettype wire
